// ==== common/sipg_pkg.sv ====
// shared types and constants for the system instruction privilege gate
package sipg_pkg;

  // privilege level width and the most privileged level
  localparam logic [1:0] SIPG_PL_ZERO = 2'h0;

  // privilege class of an instruction, one-hot
  typedef enum logic [2:0] {
    SIPG_CLS_PRIV = 3'h1,
    SIPG_CLS_OS = 3'h2,
    SIPG_CLS_ANY = 3'h4
  } sipg_cls_t;

  // instruction codes presented by the decoder; the encoding is our own
  typedef enum logic [5:0] {
    SIPG_OP_NONE = 6'h00,
    SIPG_OP_REQ_LVL_ADJ = 6'h01,
    SIPG_OP_GLB_INT_CLR = 6'h02,
    SIPG_OP_INT_FLAG_CLR = 6'h03,
    SIPG_OP_TASK_SW_CLR = 6'h04,
    SIPG_OP_HALT = 6'h05,
    SIPG_OP_BRKPT = 6'h06,
    SIPG_OP_CACHE_INVAL = 6'h07,
    SIPG_OP_PAGE_INVAL = 6'h08,
    SIPG_OP_PAGE_INVAL_ALT = 6'h09,
    SIPG_OP_INT_RETURN = 6'h0A,
    SIPG_OP_ACC_RIGHTS_LD = 6'h0B,
    SIPG_OP_GDT_LOAD = 6'h0C,
    SIPG_OP_IDT_LOAD = 6'h0D,
    SIPG_OP_LDT_LOAD = 6'h0E,
    SIPG_OP_MSW_LOAD = 6'h0F,
    SIPG_OP_SEG_LIMIT_LD = 6'h10,
    SIPG_OP_TASK_REG_LOAD = 6'h11,
    SIPG_OP_MON_SETUP = 6'h12,
    SIPG_OP_CREG_MOVE = 6'h13,
    SIPG_OP_DREG_MOVE = 6'h14,
    SIPG_OP_MON_WAIT = 6'h15,
    SIPG_OP_SEG1_BASE_RD = 6'h16,
    SIPG_OP_SEG2_BASE_RD = 6'h17,
    SIPG_OP_MSR_READ = 6'h18,
    SIPG_OP_PMC_READ = 6'h19,
    SIPG_OP_TSC_READ = 6'h1A,
    SIPG_OP_TSC_ID_READ = 6'h1B,
    SIPG_OP_SMM_RETURN = 6'h1C,
    SIPG_OP_GDT_STORE = 6'h1D,
    SIPG_OP_IDT_STORE = 6'h1E,
    SIPG_OP_SECURE_INIT = 6'h1F,
    SIPG_OP_LDT_STORE = 6'h20
  } sipg_op_t;

  // one decoded instruction with the privilege it runs under
  typedef struct packed {
    logic valid;
    sipg_op_t op;
    logic [1:0] current_privilege_level;
  } sipg_req_t;

  // verdict for one instruction
  typedef struct packed {
    logic valid;
    logic allow;
    logic prot_fault;
    sipg_cls_t cls;
  } sipg_rsp_t;

  // verdict value while reset is held
  localparam sipg_rsp_t SIPG_RSP_RST = '{valid: 1'b0, allow: 1'b0,
    prot_fault: 1'b0, cls: SIPG_CLS_PRIV};

endpackage : sipg_pkg

// ==== rtl/sipg_gate.sv ====
// privilege gate for system-management instructions
// What this block does
// RQ1: many system instructions need privilege zero; a subset runs anywhere
// RQ2: os-controlled instructions use a level set by system software
// RQ3: clear global interrupt flag only at privilege zero
// RQ4: clear task-switched flag only at privilege zero
// RQ5: invalidate page in alternate address space only at privilege zero
// RQ6: control register moves only at privilege zero
// RQ7: debug register moves only at privilege zero
// RQ8: secure init and jump only at privilege zero
// RQ9: timestamp with cpu id read is os-controlled
// RQ10: breakpoint accepted at any privilege level
// RQ11: system management mode return accepted at any level
// RQ12: requestor level adjust allowed at any level
// RQ13: segment base reads allowed at any level
// RQ14: privileged instruction above level zero is suppressed with a fault
module sipg_gate
  import sipg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire sipg_req_t req,
  input wire logic [1:0] os_max_level,
  output sipg_rsp_t rsp
);

  // ==========================================================
  // classification
  // unlisted codes fall to the privileged class, so a code the decoder
  // grows later can never run above level zero by accident
  function automatic sipg_cls_t classify(input sipg_op_t op);
    case (op)
      // RQ9 os-controlled class
      SIPG_OP_INT_FLAG_CLR, SIPG_OP_MON_SETUP, SIPG_OP_MON_WAIT,
      SIPG_OP_PMC_READ, SIPG_OP_TSC_READ, SIPG_OP_TSC_ID_READ:
        classify = SIPG_CLS_OS;
      // RQ10 RQ11 RQ12 RQ13 unprivileged subset
      SIPG_OP_REQ_LVL_ADJ, SIPG_OP_BRKPT, SIPG_OP_INT_RETURN,
      SIPG_OP_ACC_RIGHTS_LD, SIPG_OP_SEG_LIMIT_LD, SIPG_OP_SEG1_BASE_RD,
      SIPG_OP_SEG2_BASE_RD, SIPG_OP_SMM_RETURN, SIPG_OP_GDT_STORE,
      SIPG_OP_IDT_STORE, SIPG_OP_LDT_STORE:
        classify = SIPG_CLS_ANY;
      // RQ3 RQ4 RQ5 RQ6 RQ7 RQ8 all others need level zero
      default:
        classify = SIPG_CLS_PRIV;
    endcase
  endfunction : classify

  // ==========================================================
  // verdict
  wire sipg_cls_t cls_w = classify(req.op);
  wire logic at_zero_w = (req.current_privilege_level == SIPG_PL_ZERO);
  // the setting comes from a control register on this clock, so it is
  // read directly with no synchroniser
  // RQ2 os setting sets the highest level allowed
  wire logic os_ok_w = (req.current_privilege_level <= os_max_level);
  // RQ1 class against privilege
  wire logic allow_w = (cls_w == SIPG_CLS_ANY) ||
                       (cls_w == SIPG_CLS_PRIV && at_zero_w) ||
                       (cls_w == SIPG_CLS_OS && os_ok_w);
  wire logic live_w = req.valid && (req.op != SIPG_OP_NONE);

  // registered verdict, one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp <= SIPG_RSP_RST;
    end else begin
      rsp.valid <= live_w;
      rsp.allow <= live_w && allow_w;
      // RQ14 blocked instruction raises a fault
      rsp.prot_fault <= live_w && !allow_w;
      rsp.cls <= cls_w;
    end
  end

  // ==========================================================
  // checks
  // request shapes shared by the checks; each verdict is judged one edge
  // after its request, since the gate registers its answer
  sequence s_live_priv;
    live_w && (cls_w == SIPG_CLS_PRIV);
  endsequence

  sequence s_live_os;
    live_w && (cls_w == SIPG_CLS_OS);
  endsequence

  sequence s_priv_high;
    live_w && (cls_w == SIPG_CLS_PRIV) && !at_zero_w;
  endsequence

  sequence s_os_high;
    live_w && (req.op == SIPG_OP_TSC_ID_READ) &&
      (req.current_privilege_level > os_max_level);
  endsequence

  sequence s_quiet;
    !live_w;
  endsequence

  // blocked verdict step: fault up, allow down
  sequence s_blocked;
    rsp.prot_fault && !rsp.allow;
  endsequence

  property p_priv_zero;
    @(posedge clock) disable iff (rst)
    s_live_priv |=> (rsp.allow == $past(at_zero_w));
  endproperty
  a_priv_zero: assert property (p_priv_zero) // RQ1
    else $error("privileged verdict wrong");

  property p_os_level;
    @(posedge clock) disable iff (rst)
    s_live_os |=> (rsp.allow == $past(os_ok_w));
  endproperty
  a_os_level: assert property (p_os_level) // RQ2
    else $error("os-controlled verdict wrong");

  property p_glb_int_clr;
    @(posedge clock) disable iff (rst)
    (live_w && req.op == SIPG_OP_GLB_INT_CLR && !at_zero_w) |=>
      s_blocked;
  endproperty
  a_glb_int_clr: assert property (p_glb_int_clr) // RQ3
    else $error("global flag clear allowed above zero");

  property p_task_sw_clr;
    @(posedge clock) disable iff (rst)
    (live_w && req.op == SIPG_OP_TASK_SW_CLR) |=>
      (rsp.allow == $past(at_zero_w));
  endproperty
  a_task_sw_clr: assert property (p_task_sw_clr) // RQ4
    else $error("task-switched clear verdict wrong");

  property p_inv_alt;
    @(posedge clock) disable iff (rst)
    (live_w && req.op == SIPG_OP_PAGE_INVAL_ALT && !at_zero_w) |=>
      !rsp.allow;
  endproperty
  a_inv_alt: assert property (p_inv_alt) // RQ5
    else $error("alternate invalidate allowed above zero");

  property p_creg;
    @(posedge clock) disable iff (rst)
    (live_w && req.op == SIPG_OP_CREG_MOVE && !at_zero_w) |=>
      !rsp.allow;
  endproperty
  a_creg: assert property (p_creg) // RQ6
    else $error("control move allowed above zero");

  property p_dreg;
    @(posedge clock) disable iff (rst)
    (live_w && req.op == SIPG_OP_DREG_MOVE && !at_zero_w) |=>
      !rsp.allow;
  endproperty
  a_dreg: assert property (p_dreg) // RQ7
    else $error("debug move allowed above zero");

  property p_sinit;
    @(posedge clock) disable iff (rst)
    (live_w && req.op == SIPG_OP_SECURE_INIT) |=>
      (rsp.allow == $past(at_zero_w));
  endproperty
  a_sinit: assert property (p_sinit) // RQ8
    else $error("secure init verdict wrong");

  property p_tscp;
    @(posedge clock) disable iff (rst)
    (live_w && req.op == SIPG_OP_TSC_ID_READ) |=> (rsp.cls == SIPG_CLS_OS);
  endproperty
  a_tscp: assert property (p_tscp) // RQ9
    else $error("timestamp id read not os class");

  property p_any;
    @(posedge clock) disable iff (rst)
    (live_w && (req.op == SIPG_OP_BRKPT || req.op == SIPG_OP_SMM_RETURN ||
     req.op == SIPG_OP_REQ_LVL_ADJ || req.op == SIPG_OP_SEG1_BASE_RD ||
     req.op == SIPG_OP_SEG2_BASE_RD)) |=> (rsp.allow && !rsp.prot_fault);
  endproperty
  a_any: assert property (p_any) // RQ10 RQ11 RQ12 RQ13
    else $error("unprivileged instruction blocked");

  property p_fault;
    @(posedge clock) disable iff (rst)
    rsp.valid |-> (rsp.allow != rsp.prot_fault);
  endproperty
  a_fault: assert property (p_fault) // RQ14
    else $error("fault and allow not exclusive");

  // RQ3 to RQ8 fixed class, checked apart from the decode function
  property p_priv_ops;
    @(posedge clock) disable iff (rst)
    (live_w && (req.op == SIPG_OP_GLB_INT_CLR ||
     req.op == SIPG_OP_TASK_SW_CLR || req.op == SIPG_OP_PAGE_INVAL_ALT ||
     req.op == SIPG_OP_CREG_MOVE || req.op == SIPG_OP_DREG_MOVE ||
     req.op == SIPG_OP_SECURE_INIT)) |=> (rsp.cls == SIPG_CLS_PRIV);
  endproperty
  a_priv_ops: assert property (p_priv_ops) // RQ3 RQ4 RQ5 RQ6 RQ7 RQ8
    else $error("level-zero instruction not in privileged class");

  // RQ14 fault above zero
  property p_priv_fault;
    @(posedge clock) disable iff (rst)
    s_priv_high |=> s_blocked;
  endproperty
  a_priv_fault: assert property (p_priv_fault) // RQ14
    else $error("privileged instruction above zero not faulted");

  // RQ2 software limit
  property p_os_limit;
    @(posedge clock) disable iff (rst)
    s_os_high |=> s_blocked;
  endproperty
  a_os_limit: assert property (p_os_limit) // RQ2
    else $error("os-controlled instruction above limit allowed");

  // RQ1 answer follows request
  property p_answer;
    @(posedge clock) disable iff (rst)
    live_w |=> rsp.valid;
  endproperty
  a_answer: assert property (p_answer) // RQ1
    else $error("no verdict after a live instruction");

  // RQ14 no stray verdict
  property p_quiet;
    @(posedge clock) disable iff (rst)
    s_quiet |=> (!rsp.valid && !rsp.allow && !rsp.prot_fault);
  endproperty
  a_quiet: assert property (p_quiet) // RQ14
    else $error("verdict without an instruction");

  // RQ1 subset runs anywhere
  property p_any_class;
    @(posedge clock) disable iff (rst)
    (live_w && cls_w == SIPG_CLS_ANY) |=> rsp.allow;
  endproperty
  a_any_class: assert property (p_any_class) // RQ1
    else $error("any-level instruction blocked");

endmodule : sipg_gate

// ==== testbench/tb.sv ====
// self-checking bench for the system instruction privilege gate
module tb
  import sipg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  sipg_req_t req = '0;
  logic [1:0] os_max_level = 2'h1;
  sipg_rsp_t rsp;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  sipg_gate u_dut (.clock(clock), .rst(rst), .req(req),
    .os_max_level(os_max_level), .rsp(rsp));

  // ==========================================
  // clock and hang guard
  initial begin
    forever #25 clock = ~clock;
  end

  // whole run is a few hundred cycles, so this ceiling is generous
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ==========================================
  // expected class; anything unlisted is privileged
  function automatic sipg_cls_t cls_of(sipg_op_t op);
    case (op)
      SIPG_OP_INT_FLAG_CLR, SIPG_OP_MON_SETUP, SIPG_OP_MON_WAIT,
      SIPG_OP_PMC_READ, SIPG_OP_TSC_READ,
      SIPG_OP_TSC_ID_READ: return SIPG_CLS_OS;
      SIPG_OP_REQ_LVL_ADJ, SIPG_OP_BRKPT, SIPG_OP_INT_RETURN,
      SIPG_OP_ACC_RIGHTS_LD, SIPG_OP_SEG_LIMIT_LD, SIPG_OP_SEG1_BASE_RD,
      SIPG_OP_SEG2_BASE_RD, SIPG_OP_SMM_RETURN, SIPG_OP_GDT_STORE,
      SIPG_OP_IDT_STORE, SIPG_OP_LDT_STORE: return SIPG_CLS_ANY;
      default: return SIPG_CLS_PRIV;
    endcase
  endfunction : cls_of

  task automatic check(string what, logic [5:0] exp, logic [5:0] got);
    samples_checked++;
    if (exp !== got) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // one instruction in, verdict one edge later
  task automatic issue(sipg_op_t op, logic [1:0] lvl);
    sipg_cls_t c;
    logic ok;
    sipg_rsp_t e;
    c = cls_of(op);
    ok = (c == SIPG_CLS_ANY) || (c == SIPG_CLS_PRIV && lvl == SIPG_PL_ZERO)
      || (c == SIPG_CLS_OS && lvl <= os_max_level);
    e = '{valid: 1'b1, allow: ok, prot_fault: !ok, cls: c};
    req = '{valid: 1'b1, op: op, current_privilege_level: lvl};
    @(posedge clock);
    #1;
    check("verdict", e, rsp);
  endtask : issue

  // ==========================================
  // scenarios
  task automatic t_sweep();
    for (int i = 1; i <= 32; i++) begin
      for (int l = 0; l < 4; l++) begin
        issue(sipg_op_t'(6'(i)), 2'(l));
      end
    end
  endtask : t_sweep

  // software setting moves the os-class limit
  task automatic t_os_cfg();
    for (int m = 0; m < 4; m++) begin
      os_max_level = 2'(m);
      for (int l = 0; l < 4; l++) begin
        issue(SIPG_OP_TSC_ID_READ, 2'(l));
        issue(SIPG_OP_BRKPT, 2'(l));
        issue(SIPG_OP_SMM_RETURN, 2'(l));
        issue(SIPG_OP_REQ_LVL_ADJ, 2'(l));
        issue(SIPG_OP_SEG2_BASE_RD, 2'(l));
      end
    end
  endtask : t_os_cfg

  // idle cycle and the empty code give no verdict
  task automatic t_idle();
    req.valid = 1'b0;
    @(posedge clock);
    #1;
    check("idle valid", 6'h00, {5'h00, rsp.valid});
    req = '{valid: 1'b1, op: SIPG_OP_NONE, current_privilege_level: 2'h3};
    @(posedge clock);
    #1;
    check("none valid", 6'h00, {5'h00, rsp.valid});
  endtask : t_idle

  // reset in mid-run clears the verdict at once
  task automatic t_reset();
    req = '{valid: 1'b1, op: SIPG_OP_CREG_MOVE, current_privilege_level: 2'h3};
    rst = 1'b1;
    #1;
    check("reset rsp", 6'h01, rsp);
    @(posedge clock);
    #1;
    rst = 1'b0;
    issue(SIPG_OP_CREG_MOVE, 2'h3);
  endtask : t_reset

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    t_sweep();
    t_os_cfg();
    t_idle();
    t_reset();
    report_and_stop();
  end
endmodule : tb
